// ==== src/ccr_pkg.sv ====
package ccr_pkg;
    // Register map of the two control registers.
    localparam logic [7:0] CTRL_ONE_ADDR = 8'h05;
    localparam logic [7:0] CTRL_TWO_ADDR = 8'h06;
    localparam logic [7:0] CTRL_ONE_RESET = 8'h9e;
    localparam logic [7:0] CTRL_TWO_RESET = 8'he6;

    // Field positions in the first register.
    localparam int TERM_EN_BIT = 7;
    localparam int HOST_TIMEOUT_HI = 5;
    localparam int HOST_TIMEOUT_LO = 4;
    localparam int SAFETY_EN_BIT = 3;
    localparam int FAST_CHARGE_TIMER_LENGTH_BIT = 2;
    localparam int THERMAL_LIMIT_SELECT_BIT = 1;
    localparam int WARM_CHARGE_VOLTAGE_SELECT_BIT = 0;

    // Field positions in the second register.
    localparam int OVERVOLTAGE_HI = 7;
    localparam int OVERVOLTAGE_LO = 6;
    localparam int BOOST_HI = 5;
    localparam int BOOST_LO = 4;
    localparam int FLOOR_HI = 3;
    localparam int FLOOR_LO = 0;

    // Timing: the second tick is derived from the clock period.
    localparam longint SECOND_NS = 1000000000;
    localparam longint CLK_PERIOD_NS = 25;
    localparam int SECOND_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
    localparam logic [7:0] HOST_TIMEOUT_S_1 = 8'd40;
    localparam logic [7:0] HOST_TIMEOUT_S_2 = 8'd80;
    localparam logic [7:0] HOST_TIMEOUT_S_3 = 8'd160;
    localparam longint HOUR_S = 3600;
    localparam logic [16:0] PRECHARGE_S = 17'(2 * HOUR_S);
    localparam logic [16:0] FAST_LONG_S = 17'(20 * HOUR_S);
    localparam logic [16:0] FAST_SHORT_S = 17'(10 * HOUR_S);

    // Analog setting levels, in millivolts and degrees Celsius.
    localparam logic [12:0] WARM_CAP_MV = 13'd4100;
    localparam logic [13:0] OVP_MV_0 = 14'd5850;
    localparam logic [13:0] OVP_MV_1 = 14'd6400;
    localparam logic [13:0] OVP_MV_2 = 14'd11000;
    localparam logic [13:0] OVP_MV_3 = 14'd14200;
    localparam logic [12:0] BOOST_MV_0 = 13'd4600;
    localparam logic [12:0] BOOST_MV_1 = 13'd4750;
    localparam logic [12:0] BOOST_MV_2 = 13'd5000;
    localparam logic [12:0] BOOST_MV_3 = 13'd5150;
    localparam logic [12:0] FLOOR_OFFSET_MV = 13'd3900;
    localparam logic [12:0] FLOOR_STEP_MV = 13'd100;
    localparam logic [6:0] THERMAL_LOW_C = 7'd90;
    localparam logic [6:0] THERMAL_HIGH_C = 7'd110;

    // Serial bus address of the device; the value is arbitrary.
    localparam logic [6:0] DEVICE_ADDR = 7'h2c;
endpackage

// ==== src/ccr_reg_if.sv ====
`timescale 1ns/100ps
interface ccr_reg_if;
    logic wrEn;
    logic [7:0] addr;
    logic [7:0] wrData;
    logic [7:0] rdData;
    logic kick;
    modport target(output wrEn, output addr, output wrData, output kick, input rdData);
    modport regs(input wrEn, input addr, input wrData, input kick, output rdData);
endinterface

// ==== src/ccr_serial_target.sv ====
`timescale 1ns/100ps
module ccr_serial_target (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Two-wire bus pins.
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOe,
    // Register side.
    ccr_reg_if.target bus
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
    } ccr_tgt_state_e;

    typedef struct packed {
        logic sclMeta;
        logic sclSync;
        logic sclPrev;
        logic sdaMeta;
        logic sdaSync;
        logic sdaPrev;
        ccr_tgt_state_e state;
        logic [7:0] shift;
        logic [2:0] bitCnt;
        logic got8;
        logic isRead;
        logic [7:0] ptr;
        logic drive;
        logic wrEn;
        logic [7:0] wrData;
        logic kick;
    } ccr_tgt_s;

    localparam ccr_tgt_s RESET_STATE = '{state: ST_IDLE, sclMeta: 1'b1, sclSync: 1'b1,
        sclPrev: 1'b1, sdaMeta: 1'b1, sdaSync: 1'b1, sdaPrev: 1'b1, default: '0};

    ccr_tgt_s s;
    ccr_tgt_s next_s;

    always_comb begin
        logic rise;
        logic fall;
        logic startCond;
        logic stopCond;
        rise = s.sclSync & ~s.sclPrev;
        fall = ~s.sclSync & s.sclPrev;
        startCond = s.sclSync & s.sclPrev & s.sdaPrev & ~s.sdaSync;
        stopCond = s.sclSync & s.sclPrev & ~s.sdaPrev & s.sdaSync;
        next_s = s;
        next_s.sclMeta = sclIn;
        next_s.sclSync = s.sclMeta;
        next_s.sclPrev = s.sclSync;
        next_s.sdaMeta = sdaIn;
        next_s.sdaSync = s.sdaMeta;
        next_s.sdaPrev = s.sdaSync;
        next_s.wrEn = 1'b0;
        next_s.kick = 1'b0;
        if (startCond) begin
            next_s.state = ST_ADDR;
            next_s.bitCnt = 3'h0;
            next_s.got8 = 1'b0;
            next_s.drive = 1'b0;
        end else if (stopCond) begin
            next_s.state = ST_IDLE;
            next_s.drive = 1'b0;
        end else begin
            case (s.state)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (rise) begin
                        next_s.shift = {s.shift[6:0], s.sdaSync};
                        next_s.bitCnt = s.bitCnt + 3'h1;
                        next_s.got8 = (s.bitCnt == 3'h7);
                    end else if (fall && s.got8) begin
                        next_s.got8 = 1'b0;
                        next_s.drive = 1'b1;
                        if (s.state == ST_ADDR) begin
                            if (s.shift[7:1] == ccr_pkg::DEVICE_ADDR) begin
                                next_s.isRead = s.shift[0];
                                next_s.state = ST_ADDR_ACK;
                                next_s.kick = 1'b1;
                            end else begin
                                next_s.drive = 1'b0;
                                next_s.state = ST_IDLE;
                            end
                        end else if (s.state == ST_PTR) begin
                            next_s.ptr = s.shift;
                            next_s.state = ST_PTR_ACK;
                        end else begin
                            next_s.wrEn = 1'b1;
                            next_s.wrData = s.shift;
                            next_s.state = ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
                    if (fall) begin
                        next_s.drive = 1'b0;
                        next_s.bitCnt = 3'h0;
                        if (s.state == ST_WDATA_ACK) begin
                            // The pointer steps after the write so a burst fills on.
                            next_s.ptr = s.ptr + 8'h01;
                            next_s.state = ST_WDATA;
                        end else if (s.state == ST_PTR_ACK) begin
                            next_s.state = ST_WDATA;
                        end else if (s.isRead) begin
                            next_s.shift = bus.rdData;
                            next_s.ptr = s.ptr + 8'h01;
                            next_s.drive = ~bus.rdData[7];
                            next_s.state = ST_RDATA;
                        end else begin
                            next_s.state = ST_PTR;
                        end
                    end
                end
                ST_RDATA: begin
                    if (fall) begin
                        if (s.bitCnt == 3'h7) begin
                            next_s.drive = 1'b0;
                            next_s.state = ST_RDATA_ACK;
                        end else begin
                            next_s.bitCnt = s.bitCnt + 3'h1;
                            next_s.shift = {s.shift[6:0], 1'b0};
                            next_s.drive = ~s.shift[6];
                        end
                    end
                end
                ST_RDATA_ACK: begin
                    if (rise) begin
                        next_s.got8 = ~s.sdaSync;
                    end else if (fall) begin
                        next_s.got8 = 1'b0;
                        next_s.bitCnt = 3'h0;
                        if (s.got8) begin
                            next_s.shift = bus.rdData;
                            next_s.ptr = s.ptr + 8'h01;
                            next_s.drive = ~bus.rdData[7];
                            next_s.state = ST_RDATA;
                        end else begin
                            next_s.state = ST_IDLE;
                        end
                    end
                end
                default: begin
                    next_s.drive = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign sdaOe = s.drive;
    assign bus.wrEn = s.wrEn;
    assign bus.addr = s.ptr;
    assign bus.wrData = s.wrData;
    assign bus.kick = s.kick;
endmodule

// ==== src/ccr_charger_regs.sv ====
// Functional notes
// - Termination is allowed only while the termination enable bit is one.
// - Host timeout field: 00 off, 01 40 s, 10 80 s, 11 160 s.
// - Safety enable gates precharge and fast timers; precharge lasts two hours.
// - Fast-charge timer length bit: 0 gives 20 hours, 1 gives 10 hours.
// - In the warm band, select 0 caps voltage at 4.1 V; 1 uses target.
// - Overvoltage field: 5.85 V, 6.4 V, 11 V, 14.2 V, in buck and boost.
// - Boost output field: 4.6 V, 4.75 V, 5.0 V, 5.15 V.
// - Input voltage floor is 3.9 V plus 100 mV per code step.
`timescale 1ns/100ps
module ccr_charger_regs #(
    parameter int SECOND_CYCLES = ccr_pkg::SECOND_CYCLES
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Two-wire host bus; the data pin is open drain and only ever pulled low.
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Requests from the rest of the charger.
    input wire logic regDefaultsReq,
    input wire logic prechargeActive,
    input wire logic fastChargeActive,
    input wire logic batteryWarm,
    input wire logic [12:0] chargeVoltageTargetMv,
    // Settings towards the regulation loops.
    output logic terminationEnable,
    output logic safetyTimerExpired,
    output logic hostTimeoutExpired,
    output logic [12:0] chargeVoltageLimitMv,
    output logic [6:0] thermalLimitDegC,
    output logic [13:0] inputOvervoltageThresholdMv,
    output logic [12:0] boostOutputLevelMv,
    output logic [12:0] inputVoltageFloorMv
);
    typedef struct packed {
        logic [7:0] ctrlOne;
        logic [7:0] ctrlTwo;
        logic defMeta;
        logic defSync;
        logic [25:0] preCnt;
        logic secTick;
        logic [7:0] wdSec;
        logic timeout;
        logic [16:0] safeSec;
        logic [1:0] phasePrev;
        logic safeExp;
        logic termEn;
        logic [12:0] vLimit;
        logic [6:0] thermC;
        logic [13:0] ovpMv;
        logic [12:0] boostMv;
        logic [12:0] floorMv;
    } ccr_top_s;

    ccr_top_s s;
    ccr_top_s next_s;
    ccr_reg_if bus ();

    function automatic logic [7:0] timeoutLimit(input logic [1:0] code);
        case (code)
            2'h1: timeoutLimit = ccr_pkg::HOST_TIMEOUT_S_1;
            2'h2: timeoutLimit = ccr_pkg::HOST_TIMEOUT_S_2;
            2'h3: timeoutLimit = ccr_pkg::HOST_TIMEOUT_S_3;
            default: timeoutLimit = 8'h00;
        endcase
    endfunction

    function automatic logic [16:0] safetyLimit(input logic pre, input logic shortFast);
        if (pre) begin
            safetyLimit = ccr_pkg::PRECHARGE_S;
        end else begin
            safetyLimit = shortFast ? ccr_pkg::FAST_SHORT_S : ccr_pkg::FAST_LONG_S;
        end
    endfunction

    ccr_serial_target u_target (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .sdaOe(sdaOe),
        .bus(bus.target)
    );

    // Unmapped pointers read as zero and ignore writes.
    assign bus.rdData = (bus.addr == ccr_pkg::CTRL_ONE_ADDR) ? s.ctrlOne :
                        (bus.addr == ccr_pkg::CTRL_TWO_ADDR) ? s.ctrlTwo : 8'h00;

    always_comb begin
        logic [1:0] phase;
        logic [1:0] wdCode;
        logic [16:0] safeMax;
        phase = {prechargeActive, fastChargeActive};
        wdCode = s.ctrlOne[ccr_pkg::HOST_TIMEOUT_HI:ccr_pkg::HOST_TIMEOUT_LO];
        safeMax = safetyLimit(prechargeActive,
            s.ctrlOne[ccr_pkg::FAST_CHARGE_TIMER_LENGTH_BIT]);
        next_s = s;
        next_s.defMeta = regDefaultsReq;
        next_s.defSync = s.defMeta;
        next_s.timeout = 1'b0;
        next_s.secTick = (s.preCnt == 26'(SECOND_CYCLES - 1));
        next_s.preCnt = next_s.secTick ? 26'h0 : s.preCnt + 26'h1;

        if (bus.wrEn && bus.addr == ccr_pkg::CTRL_ONE_ADDR) begin
            next_s.ctrlOne = bus.wrData;
        end
        if (bus.wrEn && bus.addr == ccr_pkg::CTRL_TWO_ADDR) begin
            next_s.ctrlTwo = bus.wrData;
        end

        // Any access addressed to the device restarts the host timeout.
        if (bus.kick || wdCode == 2'h0) begin
            next_s.wdSec = 8'h00;
        end else if (s.secTick) begin
            if (s.wdSec + 8'h01 >= timeoutLimit(wdCode)) begin
                next_s.wdSec = 8'h00;
                next_s.timeout = 1'b1;
                next_s.ctrlOne = ccr_pkg::CTRL_ONE_RESET;
            end else begin
                next_s.wdSec = s.wdSec + 8'h01;
            end
        end
        if (s.defSync) begin
            next_s.ctrlOne = ccr_pkg::CTRL_ONE_RESET;
            next_s.ctrlTwo = ccr_pkg::CTRL_TWO_RESET;
        end

        // A phase change starts a fresh timer, so precharge time never eats into fast charge.
        next_s.phasePrev = phase;
        if (!s.ctrlOne[ccr_pkg::SAFETY_EN_BIT] || phase != s.phasePrev || phase == 2'h0) begin
            next_s.safeSec = 17'h0;
            next_s.safeExp = 1'b0;
        end else if (s.secTick && !s.safeExp) begin
            next_s.safeSec = s.safeSec + 17'h1;
            next_s.safeExp = (s.safeSec + 17'h1 >= safeMax);
        end

        next_s.termEn = s.ctrlOne[ccr_pkg::TERM_EN_BIT];
        next_s.thermC = s.ctrlOne[ccr_pkg::THERMAL_LIMIT_SELECT_BIT] ?
            ccr_pkg::THERMAL_HIGH_C : ccr_pkg::THERMAL_LOW_C;
        if (batteryWarm && !s.ctrlOne[ccr_pkg::WARM_CHARGE_VOLTAGE_SELECT_BIT]
                && chargeVoltageTargetMv > ccr_pkg::WARM_CAP_MV) begin
            next_s.vLimit = ccr_pkg::WARM_CAP_MV;
        end else begin
            next_s.vLimit = chargeVoltageTargetMv;
        end
        case (s.ctrlTwo[ccr_pkg::OVERVOLTAGE_HI:ccr_pkg::OVERVOLTAGE_LO])
            2'h0: next_s.ovpMv = ccr_pkg::OVP_MV_0;
            2'h1: next_s.ovpMv = ccr_pkg::OVP_MV_1;
            2'h2: next_s.ovpMv = ccr_pkg::OVP_MV_2;
            default: next_s.ovpMv = ccr_pkg::OVP_MV_3;
        endcase
        case (s.ctrlTwo[ccr_pkg::BOOST_HI:ccr_pkg::BOOST_LO])
            2'h0: next_s.boostMv = ccr_pkg::BOOST_MV_0;
            2'h1: next_s.boostMv = ccr_pkg::BOOST_MV_1;
            2'h2: next_s.boostMv = ccr_pkg::BOOST_MV_2;
            default: next_s.boostMv = ccr_pkg::BOOST_MV_3;
        endcase
        next_s.floorMv = ccr_pkg::FLOOR_OFFSET_MV + 13'(ccr_pkg::FLOOR_STEP_MV *
            13'(s.ctrlTwo[ccr_pkg::FLOOR_HI:ccr_pkg::FLOOR_LO]));
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s <= '{ctrlOne: ccr_pkg::CTRL_ONE_RESET, ctrlTwo: ccr_pkg::CTRL_TWO_RESET,
                   termEn: 1'b1, vLimit: 13'h0, thermC: ccr_pkg::THERMAL_HIGH_C,
                   ovpMv: ccr_pkg::OVP_MV_3, boostMv: ccr_pkg::BOOST_MV_2,
                   floorMv: 13'd4500, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign sdaOut = 1'b0;
    assign terminationEnable = s.termEn;
    assign safetyTimerExpired = s.safeExp;
    assign hostTimeoutExpired = s.timeout;
    assign chargeVoltageLimitMv = s.vLimit;
    assign thermalLimitDegC = s.thermC;
    assign inputOvervoltageThresholdMv = s.ovpMv;
    assign boostOutputLevelMv = s.boostMv;
    assign inputVoltageFloorMv = s.floorMv;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_term_follows_reg;
        bus.wrEn && bus.addr == ccr_pkg::CTRL_ONE_ADDR && !s.defSync && !next_s.timeout
            |=> ##1 terminationEnable == $past(bus.wrData[7], 2);
    endproperty
    a_term_follows_reg: assert property (p_term_follows_reg) else $error("term enable wrong");

    property p_timeout_restores_one;
        hostTimeoutExpired |-> s.ctrlOne == ccr_pkg::CTRL_ONE_RESET;
    endproperty
    a_timeout_restores_one: assert property (p_timeout_restores_one) else $error("timeout no reset");

    property p_timeout_keeps_two;
        s.secTick && !bus.kick && !s.defSync && !bus.wrEn |=> s.ctrlTwo == $past(s.ctrlTwo);
    endproperty
    a_timeout_keeps_two: assert property (p_timeout_keeps_two) else $error("reg two disturbed");

    property p_defaults_both;
        s.defSync |=> s.ctrlOne == ccr_pkg::CTRL_ONE_RESET && s.ctrlTwo == ccr_pkg::CTRL_TWO_RESET;
    endproperty
    a_defaults_both: assert property (p_defaults_both) else $error("defaults not loaded");

    property p_no_timeout_when_off;
        s.ctrlOne[5:4] == 2'h0 |=> !hostTimeoutExpired;
    endproperty
    a_no_timeout_when_off: assert property (p_no_timeout_when_off) else $error("timeout while off");

    property p_safety_off;
        !s.ctrlOne[3] |=> !safetyTimerExpired;
    endproperty
    a_safety_off: assert property (p_safety_off) else $error("safety timer ran");

    property p_fast_limit;
        $rose(safetyTimerExpired) && !$past(prechargeActive) |->
            $past(s.safeSec) + 17'h1 == ($past(s.ctrlOne[2]) ? 17'd36000 : 17'd72000);
    endproperty
    a_fast_limit: assert property (p_fast_limit) else $error("fast limit wrong");

    property p_warm_cap;
        batteryWarm && !s.ctrlOne[0] |=> chargeVoltageLimitMv <= 13'd4100;
    endproperty
    a_warm_cap: assert property (p_warm_cap) else $error("warm cap missed");

    property p_ovp_decode;
        s.ctrlTwo[7:6] == 2'h0 ##1 s.ctrlTwo[7:6] == 2'h0 |-> inputOvervoltageThresholdMv == 14'd5850;
    endproperty
    a_ovp_decode: assert property (p_ovp_decode) else $error("ovp decode wrong");

    property p_boost_decode;
        s.ctrlTwo[5:4] == 2'h3 ##1 s.ctrlTwo[5:4] == 2'h3 |-> boostOutputLevelMv == 13'd5150;
    endproperty
    a_boost_decode: assert property (p_boost_decode) else $error("boost decode wrong");

    property p_floor_decode;
        $stable(s.ctrlTwo) |-> inputVoltageFloorMv == 13'd3900 + 13'd100 * 13'($past(s.ctrlTwo[3:0]));
    endproperty
    a_floor_decode: assert property (p_floor_decode) else $error("floor decode wrong");

    property p_thermal;
        $stable(s.ctrlOne[1]) |-> thermalLimitDegC == (s.ctrlOne[1] ? 7'd110 : 7'd90);
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal select wrong");

    c_write_one: cover property (bus.wrEn && bus.addr == ccr_pkg::CTRL_ONE_ADDR);
    c_write_two: cover property (bus.wrEn && bus.addr == ccr_pkg::CTRL_TWO_ADDR);
    c_timeout: cover property (hostTimeoutExpired);
    c_safety: cover property (safetyTimerExpired);
endmodule

// ==== tb/ccr_host_model.sv ====
`timescale 1ns/100ps
module ccr_host_model (
    // Clock.
    input wire logic ref_clk,
    // Bus pins.
    input wire logic sdaOe,
    output logic sclIn,
    output logic sdaIn
);
    logic sdaDrv = 1'b1;
    int half = 8;
    // A pull-up holds the data line high wherever nobody pulls it low.
    assign sdaIn = sdaDrv & ~sdaOe;
    initial begin
        sclIn = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    // Data moves only while the clock is low, so no bit looks like a start or stop.
    task automatic bitIo(input logic b, output logic s);
        tick(half / 2);
        sdaDrv = b;
        tick(half / 2);
        sclIn = 1'b1;
        tick(half / 2);
        s = sdaIn;
        tick(half / 2);
        sclIn = 1'b0;
    endtask
    task automatic startCond();
        tick(half / 2);
        sdaDrv = 1'b1;
        tick(half / 2);
        sclIn = 1'b1;
        tick(half);
        sdaDrv = 1'b0;
        tick(half);
        sclIn = 1'b0;
    endtask
    task automatic stopCond();
        tick(half / 2);
        sdaDrv = 1'b0;
        tick(half / 2);
        sclIn = 1'b1;
        tick(half);
        sdaDrv = 1'b1;
        tick(half);
    endtask
    // The ninth bit is always released: an ack on writes, a final nack on reads.
    task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitIo(d[i], r[i]);
        end
        bitIo(1'b1, s);
        ack = ~s;
    endtask
    task automatic regWrite(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic k0, k1, k2;
        startCond();
        xfer({ccr_pkg::DEVICE_ADDR, 1'b0}, r, k0);
        xfer(a, r, k1);
        xfer(d, r, k2);
        stopCond();
        ok = k0 & k1 & k2;
    endtask
    task automatic regRead(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic k0, k1, k2, k3;
        startCond();
        xfer({ccr_pkg::DEVICE_ADDR, 1'b0}, r, k0);
        xfer(a, r, k1);
        startCond();
        xfer({ccr_pkg::DEVICE_ADDR, 1'b1}, r, k2);
        xfer(8'hff, d, k3);
        stopCond();
        ok = k0 & k1 & k2;
    endtask
endmodule

// ==== tb/charger_control_regs_bench.sv ====
`timescale 1ns/100ps
module charger_control_regs_bench;
    localparam int SEC = 20;
    logic ref_clk;
    logic sys_rst;
    logic sclIn, sdaIn, sdaOut, sdaOe, terminationEnable, safetyTimerExpired, hostTimeoutExpired;
    logic regDefaultsReq, prechargeActive, fastChargeActive;
    logic batteryWarm;
    logic [12:0] chargeVoltageTargetMv;
    logic [12:0] chargeVoltageLimitMv, boostOutputLevelMv, inputVoltageFloorMv;
    logic [6:0] thermalLimitDegC;
    logic [13:0] inputOvervoltageThresholdMv;
    logic [7:0] v, v6;
    int num_errors = 0, n_compared = 0, seed = 81745, cyc = 0, pulses = 0, lastPulse = 0;
    int t0, p0, per;
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (hostTimeoutExpired === 1'b1) begin
            pulses <= pulses + 1;
            lastPulse <= cyc;
        end
    end
    ccr_charger_regs #(.SECOND_CYCLES(SEC)) ccr_charger_regs_inst (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .regDefaultsReq(regDefaultsReq), .prechargeActive(prechargeActive),
        .fastChargeActive(fastChargeActive), .batteryWarm(batteryWarm),
        .chargeVoltageTargetMv(chargeVoltageTargetMv), .terminationEnable(terminationEnable),
        .safetyTimerExpired(safetyTimerExpired), .hostTimeoutExpired(hostTimeoutExpired),
        .chargeVoltageLimitMv(chargeVoltageLimitMv), .thermalLimitDegC(thermalLimitDegC),
        .inputOvervoltageThresholdMv(inputOvervoltageThresholdMv),
        .boostOutputLevelMv(boostOutputLevelMv), .inputVoltageFloorMv(inputVoltageFloorMv));
    ccr_host_model ccr_host_model_inst (.ref_clk(ref_clk), .sdaOe(sdaOe), .sclIn(sclIn),
        .sdaIn(sdaIn));
    task automatic final_report();
        $display("errors %0d, compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [13:0] got, input logic [13:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        ccr_host_model_inst.half = 8 + 4 * ($random(seed) & 1);
        ccr_host_model_inst.regWrite(a, d, ok);
        check(14'(ok), 14'h1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic ok;
        logic [7:0] d;
        ccr_host_model_inst.regRead(a, d, ok);
        check({5'h0, ok, d}, {6'h1, e});
    endtask
    function automatic logic [13:0] ovpMv(input logic [1:0] c);
        logic [13:0] t[4] = '{ccr_pkg::OVP_MV_0, ccr_pkg::OVP_MV_1, ccr_pkg::OVP_MV_2,
            ccr_pkg::OVP_MV_3};
        return t[c];
    endfunction
    function automatic logic [13:0] boostMv(input logic [1:0] c);
        logic [12:0] t[4] = '{ccr_pkg::BOOST_MV_0, ccr_pkg::BOOST_MV_1, ccr_pkg::BOOST_MV_2,
            ccr_pkg::BOOST_MV_3};
        return 14'(t[c]);
    endfunction
    function automatic logic [13:0] limitMv(input logic sel);
        if (batteryWarm && !sel && chargeVoltageTargetMv > ccr_pkg::WARM_CAP_MV)
            return 14'(ccr_pkg::WARM_CAP_MV);
        return 14'(chargeVoltageTargetMv);
    endfunction
    initial begin
        ref_clk = 1'b0;
        sys_rst = 1'b1;
        {regDefaultsReq, prechargeActive, fastChargeActive, batteryWarm} = 4'h0;
        chargeVoltageTargetMv = 13'h1068;
        ccr_host_model_inst.tick(10);
        sys_rst = 1'b0;
        ccr_host_model_inst.tick(4);
        check(14'(terminationEnable), 14'h1);
        check(14'(thermalLimitDegC), 14'h6e);
        check(inputOvervoltageThresholdMv, 14'h3778);
        check(14'(boostOutputLevelMv), 14'h1388);
        check(14'(inputVoltageFloorMv), 14'h1194);
        rd(8'h05, 8'h9e);
        rd(8'h06, 8'he6);
        for (int i = 0; i < 4; i++) begin
            v6 = {2'(i), 2'(3 - i), i == 0 ? 4'h0 : i == 3 ? 4'hf : 4'($random(seed))};
            wr(8'h06, v6);
            ccr_host_model_inst.tick(2);
            check(inputOvervoltageThresholdMv, ovpMv(v6[7:6]));
            check(14'(boostOutputLevelMv), boostMv(v6[5:4]));
            check(14'(inputVoltageFloorMv),
                14'(ccr_pkg::FLOOR_OFFSET_MV + ccr_pkg::FLOOR_STEP_MV * v6[3:0]));
            rd(8'h06, v6);
        end
        for (int i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            v[5:4] = 2'b01;
            v[0] = i[0];
            batteryWarm = 1'(i < 4 || $random(seed) & 1);
            chargeVoltageTargetMv = i < 2 ? 13'h1194 : 13'h0dac + 13'($random(seed) & 1023);
            {prechargeActive, fastChargeActive} = 2'($random(seed));
            wr(8'h05, v);
            ccr_host_model_inst.tick(2);
            check(14'(terminationEnable), 14'(v[7]));
            check(14'(thermalLimitDegC), 14'(v[1] ? ccr_pkg::THERMAL_HIGH_C :
                ccr_pkg::THERMAL_LOW_C));
            check(14'(chargeVoltageLimitMv), limitMv(v[0]));
            rd(8'h05, v);
        end
        // Expiry needs hours of ticks, so here only a quiet timer and a low data drive are seen.
        check({12'h0, sdaOut, safetyTimerExpired}, 14'h0);
        for (int c = 1; c < 4; c++) begin
            per = SEC * (40 << (c - 1));
            t0 = cyc;
            p0 = pulses;
            wr(8'h05, {2'b00, 2'(c), 4'h0});
            for (int k = 0; k < per + 2000 && pulses == p0; k++) ccr_host_model_inst.tick(1);
            check(14'(pulses - p0), 14'h1);
            check(14'(lastPulse - t0 >= per && lastPulse - t0 <= per + 400), 14'h1);
            rd(8'h05, 8'h9e);
            rd(8'h06, v6);
        end
        p0 = pulses;
        wr(8'h05, 8'h00);
        ccr_host_model_inst.tick(4000);
        check(14'(pulses - p0), 14'h0);
        rd(8'h05, 8'h00);
        wr(8'h06, 8'h00);
        regDefaultsReq = 1'b1;
        ccr_host_model_inst.tick(4);
        regDefaultsReq = 1'b0;
        ccr_host_model_inst.tick(4);
        check(14'(inputVoltageFloorMv), 14'h1194);
        rd(8'h05, 8'h9e);
        rd(8'h06, 8'he6);
        rd(8'h07, 8'h00);
        final_report();
    end
    initial begin
        repeat (80000) @(posedge ref_clk);
        num_errors++;
        final_report();
    end
endmodule
